/* design/rx_filter_pkg.sv */
// Purpose: shared constants and types of the receive address filter
// Assumes: byte-wide receive stream on the receive clock, AXI4-Lite regs
// Notes: register byte offsets, field positions and frame offsets
package rx_filter_pkg;
    localparam int NUM_ADDR = 4;
    localparam int NUM_TYPE = 4;
    localparam int AXI_AW = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] HASH_LO_OFF = 8'h04;
    localparam logic [7:0] HASH_HI_OFF = 8'h08;
    localparam logic [7:0] COUNT_OFF = 8'h0C;
    localparam logic [7:0] ADDR_BASE = 8'h10;
    localparam logic [7:0] ADDR_END = 8'h2C;
    localparam logic [7:0] TYPE_BASE = 8'h30;
    localparam logic [7:0] TYPE_END = 8'h3C;

    // field positions
    localparam int CTRL_HASH_EN = 0;
    localparam int CTRL_EXT_EN = 1;
    localparam int HI_SRC_BIT = 16;
    localparam int HI_MASK_LSB = 24;
    localparam int HI_EN_BIT = 31;
    localparam int TYPE_EN_BIT = 16;

    // frame byte positions (last byte of each header field, lowest kept last byte, count cap)
    localparam logic [5:0] DEST_LAST = 6'h05;
    localparam logic [5:0] SRC_LAST = 6'h0B;
    localparam logic [5:0] TYPE_LAST = 6'h0D;
    localparam logic [5:0] MIN_LAST = 6'h0E;
    localparam logic [5:0] CNT_MAX = 6'h3F;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        FIELD_NONE = 3'h0,
        FIELD_DEST = 3'h1,
        FIELD_SRC = 3'h2,
        FIELD_TYPE = 3'h3,
        FIELD_PAYLOAD = 3'h4
    } field_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rx_byte_t;

    typedef struct packed {
        logic keep;
        logic [1:0] queue;
    } ext_decision_t;

    typedef struct packed {
        logic enable;
        logic use_source;
        logic [5:0] mask;
        logic [47:0] addr;
    } addr_cfg_t;
endpackage

/* design/addr_filter.sv */
// Purpose: one specific-address comparator
// Assumes: destination and source addresses already captured
// Notes: byte 0 of an address is the first byte on the wire
`timescale 1ns/1ns
module addr_filter (
    input wire rx_filter_pkg::addr_cfg_t cfg, // filter settings
    input wire logic [47:0] dest_address, // captured destination
    input wire logic [47:0] source_address, // captured source
    output logic hit // filter matches
);
    import rx_filter_pkg::*;
    logic [47:0] sel;
    logic [5:0] byte_ok;

    assign sel = cfg.use_source ? source_address : dest_address;

    for (genvar b = 0; b < 6; b++) begin : g_byte
        // masked bytes always agree
        assign byte_ok[b] = cfg.mask[b] ||
            (sel[8*b +: 8] == cfg.addr[8*b +: 8]);
    end

    assign hit = cfg.enable && (&byte_ok);
endmodule

/* design/type_filter.sv */
// Purpose: one type-ID comparator
// Assumes: type/length field already captured
// Notes: disabled comparator never matches
`timescale 1ns/1ns
module type_filter (
    input wire logic enable, // comparator on
    input wire logic [15:0] value, // type-ID to match
    input wire logic [15:0] frame_type, // captured type/length
    output logic hit // comparator matches
);
    assign hit = enable && (frame_type == value);
endmodule

/* design/rx_frame_address_filter.sv */
// Purpose: receive frame filter with AXI4-Lite settings and external port
// Assumes: rx stream on aclk, one byte per rx_valid, last flags frame end
// Notes: bytes pass through one register stage; keep verdict rides last
// Function
// - four specific-address filters, each with a 48-bit address
// - each filter compares against source or destination address
// - per-byte mask excludes address bytes from comparison
// - every frame goes to DMA, dma_keep set only for matching frames
// - four type-ID values, each enabled, match the type/length field
// - optional destination hash match, enabled by configuration
// - external port shows which frame field is being presented
// - field strobe pulses once per parsed field for external capture
`timescale 1ns/1ns
module rx_frame_address_filter (
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [rx_filter_pkg::AXI_AW-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [rx_filter_pkg::AXI_AW-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic rx_valid, // received byte valid
    input wire rx_filter_pkg::rx_byte_t rx_in, // received byte
    output logic dma_valid, // byte to dma valid
    output rx_filter_pkg::rx_byte_t dma_out, // byte to dma
    output logic dma_keep, // frame kept, with dma_out.last
    output logic [1:0] dma_queue, // queue, with dma_out.last
    output rx_filter_pkg::field_t ext_field, // field being presented
    output logic ext_strobe, // field complete pulse
    output logic [47:0] ext_value, // completed field value
    input wire rx_filter_pkg::ext_decision_t ext_in // external decision
);
    import rx_filter_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RECV = 2'b10
    } state_t;

    state_t state_reg;
    logic [5:0] cnt_reg;
    logic [47:0] dest_reg, src_reg;
    logic [15:0] type_reg;
    logic [31:0] ctrl_reg, hash_lo_reg, hash_hi_reg;
    logic [31:0] addr_lo_reg [NUM_ADDR];
    logic [31:0] addr_hi_reg [NUM_ADDR];
    logic [31:0] type_cfg_reg [NUM_TYPE];
    logic [15:0] kept_reg, dropped_reg;
    addr_cfg_t cfg [NUM_ADDR];
    logic [NUM_ADDR-1:0] addr_hits;
    logic [NUM_TYPE-1:0] type_hits;
    logic [5:0] hash_idx;
    logic [63:0] hash_table;
    logic hash_hit, ext_hit, pass, frame_end, cnt_ok;
    logic [5:0] cnt_eff;

    // byte index of the current byte; a new frame restarts at zero
    assign cnt_eff = (state_reg == ST_IDLE) ? 6'h00 : cnt_reg;
    assign frame_end = rx_valid && rx_in.last;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
        end else if (rx_valid) begin
            state_reg <= rx_in.last ? ST_IDLE : ST_RECV;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 6'h00;
        end else if (rx_valid && cnt_eff != CNT_MAX) begin
            cnt_reg <= cnt_eff + 6'h01;
        end
    end

    // header capture, shifted in as bytes arrive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dest_reg <= 48'h0000_0000_0000;
            src_reg <= 48'h0000_0000_0000;
            type_reg <= 16'h0000;
        end else if (rx_valid) begin
            if (cnt_eff <= DEST_LAST) begin
                dest_reg <= {rx_in.data, dest_reg[47:8]};
            end else if (cnt_eff <= SRC_LAST) begin
                src_reg <= {rx_in.data, src_reg[47:8]};
            end else if (cnt_eff <= TYPE_LAST) begin
                type_reg <= {type_reg[7:0], rx_in.data};
            end
        end
    end

    // external port: field of the last byte taken, strobe when it completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_field <= FIELD_NONE;
        end else if (rx_valid) begin
            if (cnt_eff <= DEST_LAST) begin
                ext_field <= FIELD_DEST;
            end else if (cnt_eff <= SRC_LAST) begin
                ext_field <= FIELD_SRC;
            end else if (cnt_eff <= TYPE_LAST) begin
                ext_field <= FIELD_TYPE;
            end else begin
                ext_field <= FIELD_PAYLOAD;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_strobe <= 1'b0;
            ext_value <= 48'h0000_0000_0000;
        end else begin
            ext_strobe <= rx_valid && (cnt_eff == DEST_LAST ||
                cnt_eff == SRC_LAST || cnt_eff == TYPE_LAST);
            if (rx_valid && cnt_eff == DEST_LAST) begin
                ext_value <= {rx_in.data, dest_reg[47:8]};
            end else if (rx_valid && cnt_eff == SRC_LAST) begin
                ext_value <= {rx_in.data, src_reg[47:8]};
            end else if (rx_valid && cnt_eff == TYPE_LAST) begin
                ext_value <= {32'h0000_0000, type_reg[7:0], rx_in.data};
            end
        end
    end

    for (genvar i = 0; i < NUM_ADDR; i++) begin : g_addr
        assign cfg[i] = '{enable: addr_hi_reg[i][HI_EN_BIT],
            use_source: addr_hi_reg[i][HI_SRC_BIT],
            mask: addr_hi_reg[i][HI_MASK_LSB +: 6],
            addr: {addr_hi_reg[i][15:0], addr_lo_reg[i]}};
        addr_filter u_addr (
            .cfg(cfg[i]),
            .dest_address(dest_reg),
            .source_address(src_reg),
            .hit(addr_hits[i])
        );
    end

    for (genvar i = 0; i < NUM_TYPE; i++) begin : g_type
        type_filter u_type (
            .enable(type_cfg_reg[i][TYPE_EN_BIT]),
            .value(type_cfg_reg[i][15:0]),
            .frame_type(type_reg),
            .hit(type_hits[i])
        );
    end

    // 6-bit hash: xor of every sixth destination bit
    always_comb begin
        hash_idx = 6'h00;
        for (int k = 0; k < 8; k++) begin
            hash_idx = hash_idx ^ dest_reg[6*k +: 6];
        end
    end
    assign hash_table = {hash_hi_reg, hash_lo_reg};
    assign hash_hit = ctrl_reg[CTRL_HASH_EN] && hash_table[hash_idx];
    // external verdict sampled with the last byte, so it must be settled
    assign ext_hit = ctrl_reg[CTRL_EXT_EN] && ext_in.keep;
    // runt frames, last byte before index 14, can never be matched
    assign cnt_ok = cnt_eff >= MIN_LAST;
    assign pass = cnt_ok &&
        ((|addr_hits) || (|type_hits) || hash_hit || ext_hit);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_valid <= 1'b0;
            dma_out <= '{data: 8'h00, last: 1'b0};
            dma_keep <= 1'b0;
            dma_queue <= 2'b00;
        end else begin
            dma_valid <= rx_valid;
            dma_out <= rx_in;
            dma_keep <= frame_end && pass;
            dma_queue <= (frame_end && ctrl_reg[CTRL_EXT_EN]) ?
                ext_in.queue : 2'b00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            kept_reg <= 16'h0000;
            dropped_reg <= 16'h0000;
        end else if (frame_end) begin
            if (pass) begin
                kept_reg <= kept_reg + 16'h0001;
            end else begin
                dropped_reg <= dropped_reg + 16'h0001;
            end
        end
    end

    // AXI4-Lite slave: address and data may arrive in either order
    logic aw_have, w_have;
    logic [AXI_AW-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic [7:0] wa, ra;

    assign awready = !aw_have && !bvalid;
    assign wready = !w_have && !bvalid;
    assign arready = !rvalid;
    assign do_write = aw_have && w_have;
    assign wa = aw_addr_reg;
    assign ra = araddr;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= TYPE_END;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= ZERO_WORD;
            w_strb_reg <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (do_write) begin
                aw_have <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end else if (do_write) begin
                w_have <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= ZERO_WORD;
            hash_lo_reg <= ZERO_WORD;
            hash_hi_reg <= ZERO_WORD;
            for (int i = 0; i < NUM_ADDR; i++) begin
                addr_lo_reg[i] <= ZERO_WORD;
                addr_hi_reg[i] <= ZERO_WORD;
            end
            for (int i = 0; i < NUM_TYPE; i++) begin
                type_cfg_reg[i] <= ZERO_WORD;
            end
        end else if (do_write) begin
            if (wa == CTRL_OFF) begin
                ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
            end
            if (wa == HASH_LO_OFF) begin
                hash_lo_reg <= merge(hash_lo_reg, w_data_reg, w_strb_reg);
            end
            if (wa == HASH_HI_OFF) begin
                hash_hi_reg <= merge(hash_hi_reg, w_data_reg, w_strb_reg);
            end
            for (int i = 0; i < NUM_ADDR; i++) begin
                if (wa == ADDR_BASE + 8'(8 * i)) begin
                    addr_lo_reg[i] <= merge(addr_lo_reg[i], w_data_reg,
                        w_strb_reg);
                end
                if (wa == ADDR_BASE + 8'(8 * i + 4)) begin
                    addr_hi_reg[i] <= merge(addr_hi_reg[i], w_data_reg,
                        w_strb_reg);
                end
            end
            for (int i = 0; i < NUM_TYPE; i++) begin
                if (wa == TYPE_BASE + 8'(4 * i)) begin
                    type_cfg_reg[i] <= merge(type_cfg_reg[i], w_data_reg,
                        w_strb_reg);
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= ZERO_WORD;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
            rdata <= ZERO_WORD;
            if (ra == CTRL_OFF) begin
                rdata <= ctrl_reg;
            end else if (ra == HASH_LO_OFF) begin
                rdata <= hash_lo_reg;
            end else if (ra == HASH_HI_OFF) begin
                rdata <= hash_hi_reg;
            end else if (ra == COUNT_OFF) begin
                rdata <= {dropped_reg, kept_reg};
            end
            for (int i = 0; i < NUM_ADDR; i++) begin
                if (ra == ADDR_BASE + 8'(8 * i)) begin
                    rdata <= addr_lo_reg[i];
                end
                if (ra == ADDR_BASE + 8'(8 * i + 4)) begin
                    rdata <= addr_hi_reg[i];
                end
            end
            for (int i = 0; i < NUM_TYPE; i++) begin
                if (ra == TYPE_BASE + 8'(4 * i)) begin
                    rdata <= type_cfg_reg[i];
                end
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    runt_dropped_a: assert property (frame_end && !cnt_ok |=> !dma_keep)
        else $error("runt frame kept");
    nohit_dropped_a: assert property (frame_end && !pass |=> !dma_keep)
        else $error("unmatched frame kept");
    addr_hit_kept_a: assert property (frame_end && cnt_ok && |addr_hits
        |=> dma_keep && dma_out.last)
        else $error("address match not kept");
    // filter 1 is the source-compare filter of the bench
    src_select_a: assert property (cfg[1].enable &&
        cfg[1].use_source && cfg[1].mask == 6'h00 &&
        src_reg == cfg[1].addr |-> addr_hits[1])
        else $error("source compare missed");
    // filter 2 ignores byte 0 in the bench
    mask_byte_a: assert property (cfg[2].enable &&
        !cfg[2].use_source && cfg[2].mask == 6'h01 &&
        dest_reg[47:8] == cfg[2].addr[47:8] |-> addr_hits[2])
        else $error("masked byte blocked a match");
    type_kept_a: assert property (frame_end && cnt_ok && |type_hits
        |=> dma_keep)
        else $error("type match not kept");
    hash_off_a: assert property (!ctrl_reg[CTRL_HASH_EN] |-> !hash_hit)
        else $error("hash matched while disabled");
    dest_field_a: assert property (rx_valid && cnt_eff <= DEST_LAST
        |=> ext_field == FIELD_DEST)
        else $error("destination field not shown");
    strobe_type_a: assert property (rx_valid && cnt_eff == TYPE_LAST
        |=> ext_strobe && ext_field == FIELD_TYPE
        ##1 !ext_strobe)
        else $error("type strobe wrong");
    pass_through_a: assert property (rx_valid |=> dma_valid &&
        dma_out.data == $past(rx_in.data))
        else $error("byte not forwarded");

    frame_kept_c: cover property (frame_end ##1 dma_keep);
    frame_dropped_c: cover property (frame_end && cnt_ok ##1 !dma_keep);
    ext_keep_c: cover property (frame_end && ext_hit && !(|addr_hits));
endmodule

/* dv/ext_matcher.sv */
// Purpose: behavioural model of the fabric matching logic
// Assumes: fields latched on the strobe, decision from latched values
// Notes: keep when the type equals want_type, queue from dest byte 0
`timescale 1ns/1ns
module ext_matcher (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire rx_filter_pkg::field_t ext_field, // field shown
    input wire logic ext_strobe, // field complete pulse
    input wire logic [47:0] ext_value, // completed field value
    input wire logic [15:0] want_type, // type the fabric wants
    output rx_filter_pkg::ext_decision_t ext_in // decision to the filter
);
    import rx_filter_pkg::*;
    logic [47:0] dest_reg;
    logic [15:0] type_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dest_reg <= '0;
        end else if (ext_strobe && ext_field == FIELD_DEST) begin
            dest_reg <= ext_value;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            type_reg <= '0;
        end else if (ext_strobe && ext_field == FIELD_TYPE) begin
            type_reg <= ext_value[15:0];
        end
    end

    // settled right after the type strobe, long before the last byte
    assign ext_in.keep = (type_reg == want_type);
    assign ext_in.queue = dest_reg[1:0];
endmodule

/* dv/rx_frame_address_filter_tb.sv */
// Purpose: self-checking bench of the receive address filter
// Assumes: register and stream timing of the filter design
// Notes: frames are 20 bytes except the one below the length floor
`timescale 1ns/1ns
module rx_frame_address_filter_tb;
    import rx_filter_pkg::*;
    localparam logic [47:0] OTHER_DEST = 48'h0F0F_0F0F_0F0F;
    localparam logic [47:0] OTHER_SRC = 48'h0A0A_0A0A_0A0A;
    logic aclk = 0;
    logic aresetn = 0;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, dma_queue;
    logic rx_valid = 0, dma_valid, dma_keep, ext_strobe;
    rx_byte_t rx_in = '0, dma_out;
    field_t ext_field;
    logic [47:0] ext_value, cur_dest, cur_src;
    logic [15:0] cur_type, want_type = 16'h1234;
    ext_decision_t ext_in;
    int mismatches = 0, checked = 0, kept_n = 0, drop_n = 0, strb_cnt = 0;

    always #5 aclk = ~aclk;

    rx_frame_address_filter i_dut (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .rx_valid, .rx_in, .dma_valid, .dma_out, .dma_keep,
        .dma_queue, .ext_field, .ext_strobe, .ext_value, .ext_in);
    ext_matcher i_partner (.aclk, .aresetn, .ext_field, .ext_strobe,
        .ext_value, .want_type, .ext_in);

    task automatic chk_word(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_val(input string nm, input logic [47:0] e, g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic ga = 0;
        logic gw = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ga && gw)) begin
            @(negedge aclk);
            ga = ga || awready;
            gw = gw || wready;
            @(posedge aclk);
            if (ga) awvalid <= 0;
            if (gw) wvalid <= 0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk_word("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
        bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        chk_word("rdata", ed, rdata);
        chk_word("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
        rready <= 0;
    endtask

    function automatic logic [47:0] afn(input int i);
        return {8'h60, 8'h50, 8'h40, 8'h30, 8'(32 + i), 8'(16 + i)};
    endfunction

    function automatic logic [5:0] hidx(input logic [47:0] d);
        hidx = '0;
        for (int k = 0; k < 8; k++) hidx ^= d[6*k +: 6];
    endfunction

    function automatic logic [7:0] fbyte(input int k);
        if (k < 6) return cur_dest[8*k +: 8];
        if (k < 12) return cur_src[8*(k-6) +: 8];
        if (k == 12) return cur_type[15:8];
        if (k == 13) return cur_type[7:0];
        return 8'(k);
    endfunction

    // n is the index of the last byte
    task automatic frame(input logic [47:0] d, s, input logic [15:0] t,
                         input int n, input logic k, input logic [1:0] q);
        @(posedge aclk);
        cur_dest = d;
        cur_src = s;
        cur_type = t;
        for (int i = 0; i <= n; i++) begin
            rx_valid <= 1;
            rx_in <= {fbyte(i), i == n};
            @(posedge aclk);
        end
        rx_valid <= 0;
        rx_in <= '0;
        @(negedge aclk);
        chk_val("frame end", 48'({fbyte(n), 2'b11, k, q}),
            48'({dma_out.data, dma_valid, dma_out.last, dma_keep,
            dma_queue}));
        if (k) kept_n++;
        else drop_n++;
        @(negedge aclk);
        chk_val("strobe count", 48'(3), 48'(strb_cnt));
        strb_cnt = 0;
    endtask

    always @(posedge aclk) begin
        if (aresetn && ext_strobe) begin
            chk_val("field", 48'(strb_cnt + 1), 48'(ext_field));
            case (strb_cnt)
                0: chk_val("dest", cur_dest, ext_value);
                1: chk_val("source", cur_src, ext_value);
                default: chk_val("type", 48'(cur_type),
                    48'(ext_value[15:0]));
            endcase
            strb_cnt++;
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end

    initial begin
        logic [47:0] a;
        logic [31:0] hi;
        logic [5:0] m;
        logic [5:0] hx;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rd(CTRL_OFF, ZERO_WORD, RESP_OKAY);
        rd(COUNT_OFF, ZERO_WORD, RESP_OKAY);
        rd(8'h40, ZERO_WORD, RESP_SLVERR);
        wr(8'h40, 32'h0000_0001, 4'hF, RESP_SLVERR);
        wr(CTRL_OFF, 32'h0000_0003, 4'h0, RESP_OKAY);
        rd(CTRL_OFF, ZERO_WORD, RESP_OKAY);
        frame(afn(0), OTHER_SRC, 16'h0800, 19, 0, 0);
        for (int i = 0; i < 4; i++) begin
            a = afn(i);
            m = (i == 2) ? 6'h01 : (i == 3) ? 6'h20 : 6'h00;
            hi = {1'b1, 1'b0, m, 7'h00, 1'(i == 1), a[47:32]};
            wr(ADDR_BASE + 8'(8 * i), a[31:0], 4'hF, RESP_OKAY);
            wr(ADDR_BASE + 8'(8 * i + 4), hi, 4'hF, RESP_OKAY);
        end
        rd(ADDR_BASE + 8'h1C, hi, RESP_OKAY);
        frame(afn(0), OTHER_SRC, 16'h0800, 19, 1, 0);
        frame(OTHER_DEST, afn(1), 16'h0800, 19, 1, 0);
        frame(afn(1), OTHER_SRC, 16'h0800, 19, 0, 0);
        frame(afn(2) ^ 48'h0000_0000_00FF, OTHER_SRC, 16'h0800,
            19, 1, 0);
        frame(afn(2) ^ 48'h0000_0000_FF00, OTHER_SRC, 16'h0800,
            19, 0, 0);
        frame(afn(3) ^ 48'hFF00_0000_0000, OTHER_SRC, 16'h0800,
            19, 1, 0);
        frame(afn(0), OTHER_SRC, 16'h0800, 13, 0, 0);
        for (int i = 0; i < 4; i++) begin
            wr(TYPE_BASE + 8'(4 * i), {15'h0000, 1'(i < 3),
                16'h88A0 + 16'(i)}, 4'hF, RESP_OKAY);
        end
        for (int i = 0; i < 4; i++) begin
            frame(OTHER_DEST, OTHER_SRC, 16'h88A0 + 16'(i),
                19, 1'(i < 3), 0);
        end
        hx = hidx(OTHER_DEST);
        wr(hx[5] ? HASH_HI_OFF : HASH_LO_OFF, 32'h0000_0001 << hx[4:0],
            4'hF, RESP_OKAY);
        wr(CTRL_OFF, 32'h0000_0001, 4'hF, RESP_OKAY);
        frame(OTHER_DEST, OTHER_SRC, 16'h0800, 19, 1, 0);
        wr(CTRL_OFF, 32'h0000_0002, 4'hF, RESP_OKAY);
        frame(OTHER_DEST, OTHER_SRC, 16'h0800, 19, 0, 3);
        frame(OTHER_DEST ^ 48'h0000_0000_0001, OTHER_SRC, 16'h1234,
            19, 1, 2);
        rd(COUNT_OFF, {16'(drop_n), 16'(kept_n)}, RESP_OKAY);
        stop_test();
    end
endmodule
